// [fepc_flash_ctrl.sv]
// Purpose: Flash controller: read wait states, keyed control, page erase and programming.
// Assumes: One system bus port, request held until ready, answer after the wait states.
// Notes:   The array is modelled as a word memory inside this module.
//
// How it works
// - Wait code adds zero, one or two cycles.
// - Misaligned accesses answer with a bus error.
// - Page erase sets all 512 bytes to FF.
// - Erase on locked group aborts, sets lock flag.
// - Erase on executing page aborts, sets flag.
// - Enabled flags request interrupt; write 0 clears.
// - Control and lock writes need key 5A5A.
// - Mode 0 read, 1 program, 2 erase.
// - Aligned write in erase mode erases page.
// - Busy held high during erase or program.
// - Programming only clears bits, never sets.
// - Not-erased target bytes abort, set fail flag.
// - Program on locked group aborts, sets flag.
// - Program on executing page aborts, sets flag.
// - Aligned write in program mode programs data.
// - Security level is one whole-array register; reads are not gated by it.
// - Sixteen lock bits, eight pages each.
`timescale 1ns/1ps
`default_nettype none
module fepc_flash_ctrl
  import fepc_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic                     accReq,
  input  wire logic                     accWrite,
  input  wire logic [ADDR_W-1:0]        accAddr,
  input  wire fepc_pkg::fepc_size_t     accSize,
  input  wire logic [31:0]              accWdata,
  output logic                          accReady,
  output logic                          accError,
  output logic [31:0]                   accRdata,
  input  wire logic                     execFromFlash,
  input  wire logic [ADDR_W-1:0]        execPc,
  input  wire logic                     cfgClockEnable,
  input  wire logic                     waitWrite,
  input  wire logic [2:0]               waitData,
  input  wire logic                     mainCtrlWrite,
  input  wire logic [31:0]              mainCtrlData,
  input  wire logic                     lockWrite,
  input  wire logic [31:0]              lockData,
  input  wire logic [2:0]               irqEnable,
  input  wire logic                     flagClearWrite,
  input  wire logic [2:0]               flagClearData,
  input  wire logic [1:0]               securityLevel,
  output logic [2:0]                    waitStates,
  output fepc_pkg::fepc_mode_t          opMode,
  output logic [LOCK_W-1:0]             groupUnlock,
  output logic                          busy,
  output logic [1:0]                    security,
  output logic                          lockViolationFlag,
  output logic                          execPageViolationFlag,
  output logic                          programFailFlag,
  output logic                          irqRequest
);
  import fepc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] mem [WORDS];
  logic [3:0]  laneMask;
  logic        misaligned;
  logic        timerLoad;
  logic [TIMER_W-1:0] timerValue;
  logic        timerRunning;
  logic        timerDone;

  fepc_align_check u_align (
    .addrLow    (accAddr[1:0]),
    .size       (accSize),
    .laneMask   (laneMask),
    .misaligned (misaligned)
  );

  fepc_op_timer u_timer (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .load      (timerLoad),
    .loadValue (timerValue),
    .running   (timerRunning),
    .done      (timerDone)
  );

  function automatic logic [PAGE_W-1:0] pageOf(input logic [ADDR_W-1:0] a);
    pageOf = a[ADDR_W-1:PAGE_OFS_W];
  endfunction

  function automatic logic [3:0] groupOf(input logic [ADDR_W-1:0] a);
    groupOf = 4'(pageOf(a) >> GROUP_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Keyed and unkeyed configuration.
  logic keyOkMain;
  logic keyOkLock;
  assign keyOkMain = (mainCtrlData[31:16] == WRITE_KEY);
  assign keyOkLock = (lockData[31:16] == WRITE_KEY);

  // Wait states only take effect while the configuration clock runs.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waitStates <= WAIT_RESET;
    end else if (waitWrite && cfgClockEnable && waitData <= WAIT_MAX) begin
      waitStates <= waitData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      opMode <= FEPC_MODE_READ;
    end else if (mainCtrlWrite && keyOkMain && !busy) begin
      unique case (mainCtrlData[1:0])
        2'h0:    opMode <= FEPC_MODE_READ;
        2'h1:    opMode <= FEPC_MODE_WRITE;
        2'h2:    opMode <= FEPC_MODE_ERASE;
        default: opMode <= opMode;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      groupUnlock <= LOCK_RESET;
    end else if (lockWrite && keyOkLock) begin
      groupUnlock <= lockData[LOCK_W-1:0];
    end
  end

  // Protection level is one whole-array value, never per page.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      security <= SECURITY_RESET;
    end else begin
      security <= securityLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request checks.
  logic [WORD_AW-1:0] wordIdx;
  logic [31:0] curWord;
  logic        targetLocked;
  logic        targetExec;
  logic        notErased;
  logic        startProg;
  logic        startErase;
  logic        failLock;
  logic        failExec;
  logic        failProg;
  logic        writeOp;

  assign wordIdx      = accAddr[ADDR_W-1:2];
  assign curWord      = mem[wordIdx];
  assign targetLocked = !groupUnlock[groupOf(accAddr)];
  assign targetExec   = execFromFlash && (pageOf(execPc) == pageOf(accAddr));

  always_comb begin
    notErased = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (laneMask[b] && curWord[8*b +: 8] != ERASED_BYTE) begin
        notErased = 1'b1;
      end
    end
  end

  assign writeOp    = accReq && accReady && accWrite && !misaligned && !busy;
  assign failLock   = writeOp && opMode != FEPC_MODE_READ && targetLocked;
  assign failExec   = writeOp && opMode != FEPC_MODE_READ && !targetLocked
                      && targetExec;
  assign failProg   = writeOp && opMode == FEPC_MODE_WRITE && !targetLocked
                      && !targetExec && notErased;
  assign startProg  = writeOp && opMode == FEPC_MODE_WRITE && !targetLocked
                      && !targetExec && !notErased;
  assign startErase = writeOp && opMode == FEPC_MODE_ERASE && !targetLocked
                      && !targetExec;

  assign timerLoad  = startProg || startErase;
  assign timerValue = startErase ? TIMER_W'(ERASE_CYCLES) : TIMER_W'(PROGRAM_FAIL_FLAG_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Operation state.
  logic               opErase;
  logic [WORD_AW-1:0] opWord;
  logic [31:0]        opData;
  logic [3:0]         opLanes;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (timerLoad) begin
      busy <= 1'b1;
    end else if (timerDone) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      opErase <= 1'b0;
      opWord  <= '0;
      opData  <= '0;
      opLanes <= 4'h0;
    end else if (timerLoad) begin
      opErase <= startErase;
      opWord  <= wordIdx;
      opData  <= accWdata;
      opLanes <= laneMask;
    end
  end

  // The array changes only when the operation time ends.
  always_ff @(posedge clk_sys) begin
    if (timerDone && busy) begin
      if (opErase) begin
        for (int w = 0; w < PAGE_WORDS; w++) begin
          mem[{opWord[WORD_AW-1:PAGE_WORD_W], PAGE_WORD_W'(w)}] <= {4{ERASED_BYTE}};
        end
      end else begin
        for (int b = 0; b < 4; b++) begin
          if (opLanes[b]) begin
            mem[opWord][8*b +: 8] <= mem[opWord][8*b +: 8] & opData[8*b +: 8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Failure flags: a set in the clearing cycle wins.
  logic [2:0] flagSet;
  logic [2:0] flags;
  assign flagSet = {failProg, failExec, failLock};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flag
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          flags[gi] <= 1'b0;
        end else if (flagSet[gi]) begin
          flags[gi] <= 1'b1;
        end else if (flagClearWrite && !flagClearData[gi]) begin
          flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign lockViolationFlag     = flags[0];
  assign execPageViolationFlag = flags[1];
  assign programFailFlag       = flags[2];
  assign irqRequest            = |(flags & irqEnable);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: reads wait the configured cycles; errors answer at once.
  logic [2:0] waitCount;
  logic       inRead;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      inRead    <= 1'b0;
      waitCount <= 3'h0;
    end else if (accReq && !accWrite && !misaligned && !inRead) begin
      inRead    <= (waitStates != 3'h0);
      waitCount <= waitStates;
    end else if (inRead) begin
      waitCount <= waitCount - 3'h1;
      inRead    <= (waitCount != 3'h1);
    end
  end

  // Writes stall while busy, so the core cannot trigger a second operation.
  always_comb begin
    accReady = 1'b0;
    if (accReq) begin
      if (misaligned) begin
        accReady = 1'b1;
      end else if (accWrite) begin
        accReady = !busy;
      end else begin
        accReady = (inRead && waitCount == 3'h1) || (!inRead && waitStates == 3'h0);
      end
    end
  end

  assign accError = accReq && misaligned;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      accRdata <= 32'h0;
    end else if (accReq && !accWrite && !misaligned) begin
      accRdata <= busy ? 32'h0 : curWord;
    end
  end

endmodule
`default_nettype wire

// [fepc_pkg.sv]
// Purpose: Shared constants and types for the flash erase and program controller.
// Assumes: 64 KB array of 128 pages, 512 bytes each, 32-bit system bus.
// Notes:   All counts are in system clock cycles at 100 MHz.
package fepc_pkg;

  localparam int ADDR_W      = 16;
  localparam int PAGE_W      = 7;
  localparam int PAGE_OFS_W  = 9;
  localparam int WORDS       = 16384;
  localparam int WORD_AW     = 14;
  localparam int PAGE_WORDS  = 128;
  localparam int PAGE_WORD_W = 7;
  localparam int GROUP_SHIFT = 3;
  localparam int LOCK_W      = 16;

  localparam logic [15:0] WRITE_KEY   = 16'h5A5A;
  localparam logic [2:0]  WAIT_RESET  = 3'h0;
  localparam logic [2:0]  WAIT_MAX    = 3'h2;
  localparam logic [15:0] LOCK_RESET  = 16'h0000;
  localparam logic [1:0]  SECURITY_RESET = 2'h0;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;

  // Program and erase durations are fixed figures in microseconds.
  localparam int PROGRAM_FAIL_FLAG_TIME_US  = 20;
  localparam int ERASE_TIME_US = 4000;
  localparam int CLK_MHZ       = 100;
  localparam int PROGRAM_FAIL_FLAG_CYCLES   = PROGRAM_FAIL_FLAG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
  localparam int TIMER_W       = 20;

  typedef enum logic [1:0] {
    FEPC_MODE_READ  = 2'h0,
    FEPC_MODE_WRITE = 2'h1,
    FEPC_MODE_ERASE = 2'h2
  } fepc_mode_t;

  typedef enum logic [1:0] {
    FEPC_SIZE_BYTE = 2'h0,
    FEPC_SIZE_HALF = 2'h1,
    FEPC_SIZE_WORD = 2'h2
  } fepc_size_t;

endpackage

// [fepc_align_check.sv]
// Purpose: Decode access width into byte lanes and flag misaligned accesses.
// Assumes: Byte address low bits and a width code from the bus.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fepc_align_check
  import fepc_pkg::*;
(
  input  wire logic [1:0]       addrLow,
  input  wire fepc_pkg::fepc_size_t size,
  output logic [3:0]            laneMask,
  output logic                  misaligned
);
  import fepc_pkg::*;

  always_comb begin
    laneMask   = 4'h0;
    misaligned = 1'b0;
    unique case (size)
      FEPC_SIZE_BYTE: laneMask = 4'h1 << addrLow;
      FEPC_SIZE_HALF: begin
        laneMask   = addrLow[1] ? 4'hC : 4'h3;
        misaligned = addrLow[0];
      end
      FEPC_SIZE_WORD: begin
        laneMask   = 4'hF;
        misaligned = |addrLow;
      end
      default: misaligned = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

// [fepc_op_timer.sv]
// Purpose: Counts down the duration of an erase or program operation.
// Assumes: Load pulse with a cycle count; counts one per clock.
// Notes:   Done pulses once in the cycle the count reaches one.
`timescale 1ns/1ps
`default_nettype none
module fepc_op_timer
  import fepc_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               load,
  input  wire logic [TIMER_W-1:0] loadValue,
  output logic                    running,
  output logic                    done
);
  import fepc_pkg::*;

  logic [TIMER_W-1:0] count;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count <= '0;
    end else if (load) begin
      count <= loadValue;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign running = (count != '0);
  assign done    = (count == {{(TIMER_W-1){1'b0}}, 1'b1});

endmodule
`default_nettype wire

// [fepc_flash_ctrl_props.sv]
// Purpose: Port-level properties of the flash controller.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to every instance of the controller.
`timescale 1ns/1ps
`default_nettype none
module fepc_flash_ctrl_props
  import fepc_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 reset,
  input wire logic                 accReq,
  input wire logic                 accWrite,
  input wire logic [ADDR_W-1:0]    accAddr,
  input wire fepc_pkg::fepc_size_t accSize,
  input wire logic                 accReady,
  input wire logic                 accError,
  input wire logic                 cfgClockEnable,
  input wire logic                 waitWrite,
  input wire logic [2:0]           waitData,
  input wire logic                 mainCtrlWrite,
  input wire logic [31:0]          mainCtrlData,
  input wire logic                 lockWrite,
  input wire logic [31:0]          lockData,
  input wire logic [2:0]           irqEnable,
  input wire logic                 flagClearWrite,
  input wire logic [2:0]           flagClearData,
  input wire logic [2:0]           waitStates,
  input wire fepc_pkg::fepc_mode_t opMode,
  input wire logic [LOCK_W-1:0]    groupUnlock,
  input wire logic                 busy,
  input wire logic                 lockViolationFlag,
  input wire logic                 execPageViolationFlag,
  input wire logic                 programFailFlag,
  input wire logic                 irqRequest
);
  import fepc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  property p_misalign;
    accReq && ((accSize == FEPC_SIZE_HALF && accAddr[0])
      || (accSize == FEPC_SIZE_WORD && accAddr[1:0] != 2'h0)) |-> accReady && accError;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access not refused");
  property p_byteOk;
    accError |-> accReq && accReady && accSize != FEPC_SIZE_BYTE;
  endproperty
  a_byteOk: assert property (p_byteOk) else $error("bus error without cause");
  property p_ctrlKey;
    mainCtrlWrite && mainCtrlData[31:16] != WRITE_KEY |=> opMode == $past(opMode);
  endproperty
  a_ctrlKey: assert property (p_ctrlKey) else $error("keyless mode write taken");
  property p_lockKey;
    lockWrite && lockData[31:16] == WRITE_KEY |=> groupUnlock == $past(lockData[15:0]);
  endproperty
  a_lockKey: assert property (p_lockKey) else $error("keyed lock write lost");
  property p_wait;
    cfgClockEnable && waitWrite && waitData <= WAIT_MAX |=> waitStates == $past(waitData);
  endproperty
  a_wait: assert property (p_wait) else $error("wait code not stored");
  property p_waitBad;
    waitWrite && (!cfgClockEnable || waitData > WAIT_MAX) |=> $stable(waitStates);
  endproperty
  a_waitBad: assert property (p_waitBad) else $error("bad wait write taken");
  property p_irq;
    irqRequest == |({programFailFlag, execPageViolationFlag, lockViolationFlag} & irqEnable);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");
  property p_flagHold;
    lockViolationFlag && !(flagClearWrite && !flagClearData[0]) |=> lockViolationFlag;
  endproperty
  a_flagHold: assert property (p_flagHold) else $error("flag dropped uncleared");
  property p_busyStall;
    busy && accReq && accWrite && !accError |-> !accReady;
  endproperty
  a_busyStall: assert property (p_busyStall) else $error("write taken while busy");
endmodule
bind fepc_flash_ctrl fepc_flash_ctrl_props fepc_flash_ctrl_props_i (.clk_sys, .reset, .accReq,
  .accWrite, .accAddr, .accSize, .accReady, .accError, .cfgClockEnable, .waitWrite, .waitData,
  .mainCtrlWrite, .mainCtrlData, .lockWrite, .lockData, .irqEnable, .flagClearWrite,
  .flagClearData, .waitStates, .opMode, .groupUnlock, .busy, .lockViolationFlag,
  .execPageViolationFlag, .programFailFlag, .irqRequest);
`default_nettype wire

// [fepc_core_model.sv]
// Purpose: Core-side bus master driving the flash controller.
// Assumes: Request held until ready is sampled high.
// Notes:   Released address and write data are inverted so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module fepc_core_model
  import fepc_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 accReady,
  input  wire logic                 accError,
  input  wire logic [31:0]          accRdata,
  output logic                      accReq,
  output logic                      accWrite,
  output logic [ADDR_W-1:0]         accAddr,
  output fepc_pkg::fepc_size_t      accSize,
  output logic [31:0]               accWdata
);
  import fepc_pkg::*;
  initial begin
    accReq = 1'b0;
    accWrite = 1'b0;
    accAddr = 16'h0000;
    accSize = FEPC_SIZE_BYTE;
    accWdata = 32'h00000000;
  end
  // A stall beyond 40 cycles is left to the caller to judge.
  task automatic access(input logic w, input logic [15:0] a, input fepc_size_t s,
                        input logic [31:0] d, output logic err, output logic [31:0] rd,
                        output int lat);
    lat = 0;
    @(posedge clk_sys);
    accReq <= 1'b1;
    accWrite <= w;
    accAddr <= a;
    accSize <= s;
    accWdata <= d;
    @(posedge clk_sys);
    while (accReady !== 1'b1 && lat < 40) begin
      lat++;
      @(posedge clk_sys);
    end
    err = accError;
    accReq <= 1'b0;
    accAddr <= ~a;
    accWdata <= ~d;
    @(posedge clk_sys);
    rd = accRdata;
  endtask
endmodule
`default_nettype wire

// [test_flash_erase_program_control.sv]
// Purpose: Self-checking bench for the flash controller.
// Assumes: Array contents unknown after reset, so only refusals program.
// Notes:   A full erase outlasts the run; a second reset ends it instead.
`timescale 1ns/1ps
`default_nettype none
module test_flash_erase_program_control;
  import fepc_pkg::*;
  logic clk_sys, reset, accReq, accWrite, accReady, accError, execFromFlash, cfgClockEnable;
  logic waitWrite, mainCtrlWrite, lockWrite, flagClearWrite, busy, lockF, execF, progF, irq;
  logic [15:0] accAddr, execPc, groupUnlock;
  logic [31:0] accWdata, accRdata, mainCtrlData, lockData, rd;
  logic [2:0]  waitData, irqEnable, flagClearData, waitStates;
  logic [1:0]  securityLevel, security;
  fepc_size_t  accSize;
  fepc_mode_t  opMode;
  logic        err;
  int          lat, fail_count, n_checks, cyc;
  fepc_flash_ctrl fepc_flash_ctrl_i (.clk_sys, .reset, .accReq, .accWrite, .accAddr, .accSize,
    .accWdata, .accReady, .accError, .accRdata, .execFromFlash, .execPc, .cfgClockEnable,
    .waitWrite, .waitData, .mainCtrlWrite, .mainCtrlData, .lockWrite, .lockData, .irqEnable,
    .flagClearWrite, .flagClearData, .securityLevel, .waitStates, .opMode, .groupUnlock, .busy,
    .security, .lockViolationFlag(lockF), .execPageViolationFlag(execF),
    .programFailFlag(progF), .irqRequest(irq));
  fepc_core_model fepc_core_model_i (.clk_sys, .accReady, .accError, .accRdata, .accReq,
    .accWrite, .accAddr, .accSize, .accWdata);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cfg(input int k, input logic [31:0] d);
    @(posedge clk_sys);
    case (k)
      0: begin waitWrite <= 1'b1; waitData <= d[2:0]; end
      1: begin mainCtrlWrite <= 1'b1; mainCtrlData <= d; end
      2: begin lockWrite <= 1'b1; lockData <= d; end
      default: begin flagClearWrite <= 1'b1; flagClearData <= d[2:0]; end
    endcase
    @(posedge clk_sys);
    {waitWrite, mainCtrlWrite, lockWrite, flagClearWrite} <= 4'h0;
    #1;
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input fepc_size_t s);
    fepc_core_model_i.access(w, a, s, 32'h00000000, err, rd, lat);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_wait;
    cfg(0, 1);
    check("wait gated", 0, waitStates);
    cfgClockEnable <= 1'b1;
    cfg(0, 2);
    check("wait two", 2, waitStates);
    cfg(0, 3);
    check("wait three refused", 2, waitStates);
    bus(0, 16'h0004, FEPC_SIZE_WORD);
    check("read latency two", 2, lat);
    cfg(0, 0);
    bus(0, 16'h0008, FEPC_SIZE_WORD);
    check("read latency zero", 0, lat);
  endtask
  task automatic t_align;
    bus(0, 16'h0001, FEPC_SIZE_HALF);
    check("half odd", 1, err);
    bus(1, 16'h0002, FEPC_SIZE_WORD);
    check("word offset two", 1, err);
    bus(0, 16'h0003, FEPC_SIZE_BYTE);
    check("byte any", 0, err);
  endtask
  task automatic t_key;
    cfg(1, 32'h12340001);
    check("mode keyless", FEPC_MODE_READ, opMode);
    cfg(1, 32'h5A5A0001);
    check("mode write", FEPC_MODE_WRITE, opMode);
    cfg(2, 32'h00000002);
    check("lock keyless", 0, groupUnlock);
    cfg(2, 32'h5A5A0002);
    check("group one open", 16'h0002, groupUnlock);
  endtask
  task automatic t_lock;
    irqEnable <= 3'h1;
    bus(1, 16'h0FFC, FEPC_SIZE_WORD);
    check("program locked", 1, lockF);
    check("no busy", 0, busy);
    check("irq", 1, irq);
    cfg(3, 3'h7);
    check("clear by one", 1, lockF);
    cfg(3, 3'h6);
    check("cleared", 0, lockF);
  endtask
  task automatic t_exec;
    execFromFlash <= 1'b1;
    execPc <= 16'h1010;
    bus(1, 16'h1004, FEPC_SIZE_WORD);
    check("program pc page", 1, execF);
    cfg(1, 32'h5A5A0002);
    bus(1, 16'h3000, FEPC_SIZE_HALF);
    check("erase locked", 1, lockF);
    cfg(3, 3'h5);
    bus(1, 16'h1100, FEPC_SIZE_BYTE);
    check("erase pc page", 1, execF);
    check("lock flag kept", 1, lockF);
    check("no erase", 0, busy);
  endtask
  task automatic t_erase;
    execFromFlash <= 1'b0;
    bus(1, 16'h1200, FEPC_SIZE_WORD);
    check("erase starts", 1, busy);
    repeat (1000) @(posedge clk_sys);
    #1;
    check("busy held", 1, busy);
    cfg(1, 32'h5A5A0000);
    check("mode held busy", FEPC_MODE_ERASE, opMode);
    bus(0, 16'h0004, FEPC_SIZE_WORD);
    check("read busy zero", 0, rd);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    check("busy after reset", 0, busy);
  endtask
  initial begin
    {reset, cfgClockEnable, waitWrite, mainCtrlWrite, lockWrite, flagClearWrite} = 6'h20;
    {execFromFlash, execPc, waitData, irqEnable, flagClearData} = 26'h0;
    {mainCtrlData, lockData} = 64'h0;
    securityLevel = 2'h1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("mode reset", FEPC_MODE_READ, opMode);
    check("security", 1, security);
    t_wait();
    t_align();
    t_key();
    t_lock();
    t_exec();
    t_erase();
    wrap_up();
  end
endmodule
`default_nettype wire
